/* hdl/mtbs_regs.svh */
// Constants for the multi-transfer bus sequencer
`ifndef MTBS_REGS_SVH
`define MTBS_REGS_SVH
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
`define SZ_RSVD 2'h3
`define STEP_WIDE 32'h4
`define STEP_NARROW 32'h2
`define WORD_STEP 32'h4
`define PC_REG 4'hf
`define LINK_REG 4'he
`endif

/* hdl/mtbs_pkg.sv */
// Types shared by the multi-transfer bus sequencer
`default_nettype none
package mtbs_pkg;
  typedef enum logic [1:0] {
    OP_LOAD = 2'b00,
    OP_STORE = 2'b01,
    OP_SWAP = 2'b10,
    OP_EXC = 2'b11
  } op_kind_t;
  typedef enum logic [1:0] {
    EX_TRAP = 2'b00,
    EX_PREFETCH = 2'b01,
    EX_DATA = 2'b10,
    EX_OTHER = 2'b11
  } exc_kind_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_LD1 = 4'b0001,
    S_LDDAT = 4'b0010,
    S_LDINT = 4'b0011,
    S_LDPC1 = 4'b0100,
    S_LDPC2 = 4'b0101,
    S_ST1 = 4'b0110,
    S_STDAT = 4'b0111,
    S_SW1 = 4'b1000,
    S_SWRD = 4'b1001,
    S_SWWR = 4'b1010,
    S_SWEND = 4'b1011,
    S_EX1 = 4'b1100,
    S_EX2 = 4'b1101,
    S_EX3 = 4'b1110
  } state_t;
endpackage
`default_nettype wire

/* hdl/seq_reg_picker.sv */
// Lowest-set-register picker for transfer lists
`default_nettype none
module seq_reg_picker #(
  parameter int N = 16,
  parameter int IW = 4
)
(
  input wire logic [N-1:0] regSet, // Registers still to move
  output logic [IW-1:0] lowIdx, // Lowest listed register
  output logic [N-1:0] restSet, // List without that register
  output logic anySet // List not empty
);
  logic [N:0] seen;
  logic [N-1:0] oneHot;
  logic [IW-1:0] idxAcc [0:N];
  assign seen[0] = 1'b0;
  assign idxAcc[0] = '0;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      assign oneHot[i] = regSet[i] & ~seen[i];
      assign seen[i+1] = seen[i] | regSet[i];
      assign idxAcc[i+1] = idxAcc[i] | (oneHot[i] ? IW'(i) : '0);
    end
  endgenerate
  assign lowIdx = idxAcc[N];
  assign restSet = regSet & ~oneHot;
  assign anySet = seen[N];
endmodule // seq_reg_picker
`default_nettype wire

/* hdl/seq_wb_buffer.sv */
// Two-entry write-back buffer with valid/ready on both sides
`default_nettype none
module seq_wb_buffer #(
  parameter int WIDTH = 36
)
(
  input wire logic clk, // Core clock
  input wire logic rstN, // Synchronised reset, active low
  input wire logic inValid, // Entry offered
  input wire logic [WIDTH-1:0] inData, // Entry content
  output logic inReady, // Room for an entry
  output logic outValid, // Head entry present
  output logic [WIDTH-1:0] outData, // Head entry
  input wire logic outReady // Consumer takes head
);
  logic headV_ff;
  logic tailV_ff;
  logic [WIDTH-1:0] head_ff;
  logic [WIDTH-1:0] tail_ff;
  wire pop = headV_ff & outReady;
  wire push = inValid & ~tailV_ff;
  wire headFromTail = pop & tailV_ff;
  wire headFromIn = push & (~headV_ff | (pop & ~tailV_ff));
  wire loadTail = push & headV_ff & ~pop;
  wire nxt_headV = headFromTail | headFromIn | (headV_ff & ~pop);
  wire nxt_tailV = loadTail | (tailV_ff & ~pop);
  // Ready depends only on a flop, so no path from consumer to producer
  assign inReady = ~tailV_ff;
  assign outValid = headV_ff;
  assign outData = head_ff;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      headV_ff <= 1'b0;
      tailV_ff <= 1'b0;
      head_ff <= '0;
      tail_ff <= '0;
    end
    else
    begin
      headV_ff <= nxt_headV;
      tailV_ff <= nxt_tailV;
      head_ff <= headFromTail ? tail_ff : (headFromIn ? inData : head_ff);
      tail_ff <= loadTail ? inData : tail_ff;
    end
  end
endmodule // seq_wb_buffer
`default_nettype wire

/* hdl/multi_transfer_bus_sequencer.sv */
// Bus cycle sequencer for block transfers, swap and exception entry
`include "mtbs_regs.svh"
`default_nettype none
module multi_transfer_bus_sequencer
(
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic opStart, // Start pulse, taken when idle
  input wire mtbs_pkg::op_kind_t opKind, // Operation to run
  input wire mtbs_pkg::exc_kind_t excKind, // Exception type
  input wire logic [15:0] regList, // Registers to transfer
  input wire logic [31:0] pcValue, // Program counter base
  input wire logic [31:0] firstAddr, // First data address
  input wire logic [31:0] updatedBase, // Base after update
  input wire logic [3:0] baseReg, // Base register number
  input wire logic [31:0] vectorAddress, // Exception vector
  input wire logic [3:0] swapDest, // Swap destination register
  input wire logic [31:0] swapSource, // Swap source value
  input wire logic swapByte, // Swap is byte sized
  input wire logic userMode, // Core in user mode
  input wire logic compressedIsaState, // 16-bit instruction state
  input wire logic [31:0] readData, // Memory read data
  input wire logic dataAbort, // Access aborted
  input wire logic [31:0] storeRegData, // Value of storeRegSel
  input wire logic regWrReady, // Register file takes write
  output logic [31:0] address, // Bus address
  output logic [1:0] accessSize, // Access size code
  output logic writeNotRead, // High for write
  output logic memoryRequestN, // Memory request, active low
  output logic consecutiveAccess, // Sequential next access
  output logic instructionFetchN, // Opcode fetch, active low
  output logic privilegedAccessN, // Low in user mode, except high for the two vector fetches
  output logic busLock, // Locked access pair
  output logic compressedIsaOut, // Instruction state shown
  output logic [31:0] writeData, // Store data
  output logic [3:0] storeRegSel, // Register to read for store
  output wire logic regWrValid, // Register write offered
  output wire logic [3:0] regWrIndex, // Register write number
  output wire logic [31:0] regWrData, // Register write value
  output logic baseWrValid, // Base write pulse
  output logic [3:0] baseWrIndex, // Base register number
  output logic [31:0] baseWrData, // Base write value
  output logic pipelineFlush, // Pipeline invalidate pulse
  output logic excEntry, // Mode change and status save
  output logic busy // Operation in progress
);
  logic rstSync1_ff;
  logic rstSync2_ff;
  wire rstN = rstSync2_ff;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end
    else
    begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  mtbs_pkg::state_t state_ff;
  mtbs_pkg::state_t nxtState;
  mtbs_pkg::state_t stepState;
  logic [15:0] listRem_ff;
  logic [3:0] curDest_ff;
  logic aborted_ff;
  logic pcLoad_ff;
  logic cState_ff;
  logic user_ff;
  logic swapByte_ff;
  logic [31:0] pcBase_ff;
  logic [31:0] dataAddr_ff;
  logic [31:0] baseHold_ff;
  logic [31:0] newPc_ff;
  logic [31:0] vector_ff;
  logic [31:0] swapSrc_ff;
  logic [31:0] swapRead_ff;
  logic [3:0] swapDest_ff;
  logic [3:0] pickIdx;
  logic [15:0] pickRest;
  logic pickAny;
  logic [3:0] nxtSel;
  logic bufInReady;
  logic [15:0] nxtListRem;

  seq_reg_picker #(.N(16), .IW(4)) u_pick (
    .regSet(listRem_ff),
    .lowIdx(pickIdx),
    .restSet(pickRest),
    .anySet(pickAny)
  );
  seq_reg_picker #(.N(16), .IW(4)) u_pick_next (
    .regSet(nxtListRem),
    .lowIdx(nxtSel),
    .restSet(),
    .anySet()
  );

  wire isIdle = (state_ff == mtbs_pkg::S_IDLE);
  wire inLdDat = (state_ff == mtbs_pkg::S_LDDAT);
  wire inLdInt = (state_ff == mtbs_pkg::S_LDINT);
  wire inSwEnd = (state_ff == mtbs_pkg::S_SWEND);
  wire inEx1 = (state_ff == mtbs_pkg::S_EX1);
  wire inEx2 = (state_ff == mtbs_pkg::S_EX2);
  wire firstData = (state_ff == mtbs_pkg::S_LD1) || (state_ff == mtbs_pkg::S_ST1);
  wire listOp = (opKind == mtbs_pkg::OP_LOAD) || (opKind == mtbs_pkg::OP_STORE);
  wire swapInCompressed = (opKind == mtbs_pkg::OP_SWAP) && compressedIsaState;
  wire startOk = opStart && isIdle && !swapInCompressed && (!listOp || (|regList));
  wire memAccess = inLdDat || (state_ff == mtbs_pkg::S_SWRD) || (state_ff == mtbs_pkg::S_SWWR);
  wire nxtAborted = aborted_ff || (memAccess && dataAbort);
  // Cycle one is issued before the start values are held, so idle reads them live
  wire cNow = isIdle ? compressedIsaState : cState_ff;
  wire [31:0] stepL = cNow ? `STEP_NARROW : `STEP_WIDE;
  wire [31:0] startStep = compressedIsaState ? `STEP_NARROW : `STEP_WIDE;
  wire [1:0] instrSize = cNow ? `SZ_HALF : `SZ_WORD;
  wire excAfter = (excKind == mtbs_pkg::EX_DATA) || (excKind == mtbs_pkg::EX_OTHER);
  wire [31:0] excBase = excAfter ? pcValue + startStep : pcValue;
  wire [31:0] startBase = (opKind == mtbs_pkg::OP_EXC) ? excBase : pcValue;
  wire [31:0] pcPlus2 = (isIdle ? startBase : pcBase_ff) + (stepL << 1);
  wire [31:0] pcPlus3 = pcPlus2 + stepL;
  // Write-back requests share one buffer port
  wire pushLd = inLdDat && !nxtAborted;
  wire pushSw = inSwEnd && !aborted_ff;
  wire pushEx = inEx1 || inEx2;
  wire pushReq = pushLd || pushSw || pushEx;
  wire bufEmpty = !regWrValid && bufInReady;
  // Base restore must land after any queued loads, so wait for drain
  wire waitDrain = inLdInt && aborted_ff && !bufEmpty;
  wire stall = (pushReq && !bufInReady) || waitDrain;
  wire bufPush = pushReq && bufInReady;
  wire [31:0] linkVal = inEx1 ? pcBase_ff : pcBase_ff + stepL;
  wire [35:0] bufIn = pushLd ? {curDest_ff, readData} :
                      (pushSw ? {swapDest_ff, swapRead_ff} : {`LINK_REG, linkVal});
  wire enterData = !stall && ((nxtState == mtbs_pkg::S_LDDAT) || (nxtState == mtbs_pkg::S_STDAT));
  wire [31:0] nxtDataAddr = firstData ? dataAddr_ff : dataAddr_ff + `WORD_STEP;
  wire [31:0] rowDataAddr = stall ? dataAddr_ff : nxtDataAddr;
  wire rowLast = stall ? (listRem_ff == 16'h0000) : (pickRest == 16'h0000);
  wire pcTaken = pcLoad_ff && !nxtAborted;
  assign nxtListRem = startOk ? regList : (enterData ? pickRest : listRem_ff);

  seq_wb_buffer #(.WIDTH(36)) u_wb (
    .clk(core_clk),
    .rstN(rstN),
    .inValid(bufPush),
    .inData(bufIn),
    .inReady(bufInReady),
    .outValid(regWrValid),
    .outData({regWrIndex, regWrData}),
    .outReady(regWrReady)
  );

  always_comb
  begin
    stepState = state_ff;
    case (state_ff)
      mtbs_pkg::S_IDLE:
      begin
        if (startOk)
        begin
          case (opKind)
            mtbs_pkg::OP_LOAD: stepState = mtbs_pkg::S_LD1;
            mtbs_pkg::OP_STORE: stepState = mtbs_pkg::S_ST1;
            mtbs_pkg::OP_SWAP: stepState = mtbs_pkg::S_SW1;
            default: stepState = mtbs_pkg::S_EX1;
          endcase
        end
      end
      mtbs_pkg::S_LD1: stepState = mtbs_pkg::S_LDDAT;
      mtbs_pkg::S_LDDAT: stepState = pickAny ? mtbs_pkg::S_LDDAT : mtbs_pkg::S_LDINT;
      mtbs_pkg::S_LDINT: stepState = pcTaken ? mtbs_pkg::S_LDPC1 : mtbs_pkg::S_IDLE;
      mtbs_pkg::S_LDPC1: stepState = mtbs_pkg::S_LDPC2;
      mtbs_pkg::S_LDPC2: stepState = mtbs_pkg::S_IDLE;
      mtbs_pkg::S_ST1: stepState = mtbs_pkg::S_STDAT;
      mtbs_pkg::S_STDAT: stepState = pickAny ? mtbs_pkg::S_STDAT : mtbs_pkg::S_IDLE;
      mtbs_pkg::S_SW1: stepState = mtbs_pkg::S_SWRD;
      mtbs_pkg::S_SWRD: stepState = mtbs_pkg::S_SWWR;
      mtbs_pkg::S_SWWR: stepState = mtbs_pkg::S_SWEND;
      mtbs_pkg::S_SWEND: stepState = mtbs_pkg::S_IDLE;
      mtbs_pkg::S_EX1: stepState = mtbs_pkg::S_EX2;
      mtbs_pkg::S_EX2: stepState = mtbs_pkg::S_EX3;
      mtbs_pkg::S_EX3: stepState = mtbs_pkg::S_IDLE;
      default: stepState = mtbs_pkg::S_IDLE;
    endcase
    nxtState = stall ? state_ff : stepState;
  end

  // Bus row of the cycle about to start
  logic [31:0] nA;
  logic [1:0] nSz;
  logic write_not_read;
  logic nMq;
  logic nSq;
  logic nOp;
  logic nPr;
  logic nLk;
  logic nTb;
  always_comb
  begin
    nA = address;
    nSz = `SZ_WORD;
    write_not_read = 1'b0;
    nMq = 1'b1;
    nSq = 1'b0;
    nOp = 1'b1;
    nPr = isIdle ? !userMode : !user_ff;
    nLk = 1'b0;
    nTb = isIdle ? compressedIsaState : cState_ff;
    case (nxtState)
      mtbs_pkg::S_IDLE: nA = address;
      mtbs_pkg::S_LD1, mtbs_pkg::S_ST1, mtbs_pkg::S_SW1, mtbs_pkg::S_EX1:
      begin
        nA = pcPlus2;
        nSz = instrSize;
        nMq = 1'b0;
        nOp = 1'b0;
      end
      mtbs_pkg::S_LDDAT:
      begin
        nA = rowDataAddr;
        nMq = rowLast;
        nSq = !rowLast;
      end
      mtbs_pkg::S_LDINT:
      begin
        nA = pcPlus3;
        nSz = instrSize;
        nMq = 1'b0;
        nSq = !pcTaken;
      end
      mtbs_pkg::S_LDPC1, mtbs_pkg::S_LDPC2:
      begin
        nA = (nxtState == mtbs_pkg::S_LDPC1) ? newPc_ff : newPc_ff + stepL;
        nSz = instrSize;
        nMq = 1'b0;
        nSq = 1'b1;
        nOp = 1'b0;
      end
      mtbs_pkg::S_STDAT:
      begin
        nA = rowDataAddr;
        write_not_read = 1'b1;
        nMq = 1'b0;
        nSq = !rowLast;
      end
      mtbs_pkg::S_SWRD, mtbs_pkg::S_SWWR:
      begin
        nA = dataAddr_ff;
        nSz = swapByte_ff ? `SZ_BYTE : `SZ_WORD;
        write_not_read = (nxtState == mtbs_pkg::S_SWWR);
        nMq = (nxtState == mtbs_pkg::S_SWWR);
        nLk = 1'b1;
      end
      mtbs_pkg::S_SWEND:
      begin
        nA = pcPlus3;
        nMq = 1'b0;
        nSq = 1'b1;
      end
      mtbs_pkg::S_EX2, mtbs_pkg::S_EX3:
      begin
        nA = (nxtState == mtbs_pkg::S_EX2) ? vector_ff : vector_ff + `WORD_STEP;
        nMq = 1'b0;
        nSq = 1'b1;
        nOp = 1'b0;
        nPr = 1'b1;
        nTb = 1'b0;
      end
      default: nA = address;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      address <= 32'h00000000;
      accessSize <= `SZ_WORD;
      writeNotRead <= 1'b0;
      memoryRequestN <= 1'b1;
      consecutiveAccess <= 1'b0;
      instructionFetchN <= 1'b1;
      privilegedAccessN <= 1'b0;
      busLock <= 1'b0;
      compressedIsaOut <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      address <= nA;
      accessSize <= nSz;
      writeNotRead <= write_not_read;
      memoryRequestN <= nMq;
      consecutiveAccess <= nSq;
      instructionFetchN <= nOp;
      privilegedAccessN <= nPr;
      busLock <= nLk;
      compressedIsaOut <= nTb;
      busy <= (nxtState != mtbs_pkg::S_IDLE);
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_ff <= mtbs_pkg::S_IDLE;
      listRem_ff <= 16'h0000;
      curDest_ff <= 4'h0;
      storeRegSel <= 4'h0;
      aborted_ff <= 1'b0;
      dataAddr_ff <= 32'h00000000;
      writeData <= 32'h00000000;
    end
    else
    begin
      state_ff <= nxtState;
      listRem_ff <= nxtListRem;
      storeRegSel <= nxtSel;
      aborted_ff <= startOk ? 1'b0 : nxtAborted;
      curDest_ff <= enterData ? pickIdx : curDest_ff;
      dataAddr_ff <= startOk ? firstAddr : (enterData ? nxtDataAddr : dataAddr_ff);
      if (enterData && (nxtState == mtbs_pkg::S_STDAT))
        writeData <= storeRegData;
      else if (!stall && (nxtState == mtbs_pkg::S_SWWR))
        writeData <= swapSrc_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pcLoad_ff <= 1'b0;
      cState_ff <= 1'b0;
      user_ff <= 1'b0;
      swapByte_ff <= 1'b0;
      pcBase_ff <= 32'h00000000;
      baseHold_ff <= 32'h00000000;
      baseWrIndex <= 4'h0;
      vector_ff <= 32'h00000000;
      swapSrc_ff <= 32'h00000000;
      swapDest_ff <= 4'h0;
    end
    else if (startOk)
    begin
      pcLoad_ff <= regList[15] && (opKind == mtbs_pkg::OP_LOAD);
      cState_ff <= compressedIsaState;
      user_ff <= userMode;
      swapByte_ff <= swapByte;
      pcBase_ff <= startBase;
      baseHold_ff <= updatedBase;
      baseWrIndex <= baseReg;
      vector_ff <= vectorAddress;
      swapSrc_ff <= swapSource;
      swapDest_ff <= swapDest;
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      newPc_ff <= 32'h00000000;
      swapRead_ff <= 32'h00000000;
      baseWrValid <= 1'b0;
      baseWrData <= 32'h00000000;
      pipelineFlush <= 1'b0;
      excEntry <= 1'b0;
    end
    else
    begin
      if (inLdDat && (curDest_ff == `PC_REG))
        newPc_ff <= readData;
      if (state_ff == mtbs_pkg::S_SWRD)
        swapRead_ff <= readData;
      baseWrValid <= (state_ff == mtbs_pkg::S_LD1) || (inLdInt && aborted_ff && !stall);
      baseWrData <= baseHold_ff;
      pipelineFlush <= inLdInt && !stall && pcTaken;
      excEntry <= isIdle && startOk && (opKind == mtbs_pkg::OP_EXC);
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstN);

  sequence seqSwapPair;
    busLock && !writeNotRead ##1 busLock && writeNotRead && memoryRequestN;
  endsequence
  sequence seqVectorFetch;
    (address == vector_ff) && !instructionFetchN && consecutiveAccess && privilegedAccessN
      ##1 (address == vector_ff + `WORD_STEP) && !instructionFetchN && !compressedIsaOut;
  endsequence

  AST_SWAP_LOCK: assert property ((state_ff == mtbs_pkg::S_SW1) |=> seqSwapPair ##1 !busLock)
    else $error("swap lock pair wrong");
  AST_SWAP_SIZE: assert property (busLock |-> (accessSize != `SZ_HALF))
    else $error("swap used halfword size");
  AST_SWAP_END: assert property ((state_ff == mtbs_pkg::S_SWEND) |-> consecutiveAccess && !memoryRequestN
    && (accessSize == `SZ_WORD) && !busLock)
    else $error("swap end cycle wrong");
  AST_LD_SEQ: assert property (inLdDat && !stall && (pickRest != 16'h0000)
    |=> !memoryRequestN && consecutiveAccess && !writeNotRead)
    else $error("middle load read not sequential");
  AST_LD_LAST: assert property (inLdDat && (listRem_ff == 16'h0000) |-> memoryRequestN && !consecutiveAccess)
    else $error("last load read keeps request");
  AST_ST_DIR: assert property ((state_ff == mtbs_pkg::S_STDAT) |-> writeNotRead && !memoryRequestN)
    else $error("store cycle not a write");
  AST_ABORT_MUTE: assert property (inLdDat && aborted_ff |-> !bufPush)
    else $error("write after abort");
  AST_PC_FLUSH: assert property (inLdInt && !stall && pcTaken |=> pipelineFlush && (address == newPc_ff)
    && !instructionFetchN ##1 (address == $past(newPc_ff) + stepL))
    else $error("counter reload sequence wrong");
  AST_EXC_FETCH: assert property (inEx1 && !stall && bufEmpty |=> seqVectorFetch)
    else $error("vector fetches wrong");
  AST_NO_SWAP_COMP: assert property (isIdle && opStart && swapInCompressed |=> isIdle)
    else $error("swap started in compressed state");
  AST_SIZE_CODE: assert property (accessSize != `SZ_RSVD)
    else $error("reserved size code");
endmodule // multi_transfer_bus_sequencer
`default_nettype wire

/* bench/mem_model.sv */
// Memory partner: returns a word made from the address, aborts on command
`default_nettype none
module mem_model
(
  input wire logic clk, // Core clock
  input wire logic [31:0] address, // Bus address
  input wire logic writeNotRead, // High for write
  input wire logic abortOn, // Bench asks for an abort
  input wire logic [31:0] abortAt, // Address that aborts
  output logic [31:0] readData, // Read word
  output logic dataAbort // Abort answer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    readData = 32'h0;
    dataAbort = 1'b0;
  end
  // Locked pairs answered back to back, nothing slipped between
  always @(negedge clk)
  begin
    // Write cycles toggle the word, so a stale word never passes for a read
    readData <= writeNotRead ? ~readData : address ^ 32'h5a5a0000;
    dataAbort <= abortOn && address == abortAt;
  end
endmodule // mem_model
`default_nettype wire

/* bench/multi_transfer_bus_sequencer_tb.sv */
// Self-checking bench for the multi-transfer bus sequencer
`default_nettype none
module multi_transfer_bus_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PC = 32'h1000;
  localparam logic [31:0] FA = 32'h2000;
  localparam logic [31:0] K = 32'h5a5a0000;
  localparam logic [31:0] SD = 32'hc0de0000;
  logic core_clk = 0, reset_n = 0, opStart = 0, swapByte = 0, userMode = 0, compressedIsaState = 0;
  logic regWrReady = 1, abortOn = 0, dataAbort;
  mtbs_pkg::op_kind_t opKind = mtbs_pkg::OP_LOAD;
  mtbs_pkg::exc_kind_t excKind = mtbs_pkg::EX_TRAP;
  logic [15:0] regList = 16'h0;
  logic [31:0] pcValue = PC, firstAddr = FA, abortAt = 32'h0, readData, storeRegData, address, writeData;
  logic [31:0] regWrData, baseWrData, bwd;
  logic [1:0] accessSize;
  logic writeNotRead, memoryRequestN, consecutiveAccess, instructionFetchN, privilegedAccessN, busLock;
  logic compressedIsaOut, regWrValid, baseWrValid, pipelineFlush, excEntry, busy;
  logic [3:0] storeRegSel, regWrIndex, baseWrIndex;
  logic [31:0] ra [1:20];
  logic [31:0] wd [1:20];
  logic [8:0] rf [1:20];
  logic [35:0] wq [$];
  int err_count = 0, checked = 0, nrow, nbw, nfl, nex;
  assign storeRegData = SD ^ {28'h0, storeRegSel};
  always #5 core_clk = ~core_clk;
  multi_transfer_bus_sequencer dut_u (.core_clk, .reset_n, .opStart, .opKind, .excKind, .regList, .pcValue,
    .firstAddr, .updatedBase(32'h2040), .baseReg(4'h5), .vectorAddress(32'h1c), .swapDest(4'h7),
    .swapSource(32'h0bad0bad), .swapByte, .userMode, .compressedIsaState, .readData, .dataAbort,
    .storeRegData, .regWrReady, .address, .accessSize, .writeNotRead, .memoryRequestN, .consecutiveAccess,
    .instructionFetchN, .privilegedAccessN, .busLock, .compressedIsaOut, .writeData, .storeRegSel,
    .regWrValid, .regWrIndex, .regWrData, .baseWrValid, .baseWrIndex, .baseWrData, .pipelineFlush,
    .excEntry, .busy);
  mem_model mem_u (.clk(core_clk), .address, .writeNotRead, .abortOn, .abortAt, .readData, .dataAbort);
  always @(posedge core_clk)
  begin
    if (regWrValid && regWrReady)
      wq.push_back({regWrIndex, regWrData});
    if (baseWrValid)
      bwd = baseWrData;
    nbw += baseWrValid;
    nfl += pipelineFlush;
    nex += excEntry;
  end
  task automatic chk(string n, logic [35:0] e, logic [35:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Rows recorded at the falling edge, once settled
  task automatic run(mtbs_pkg::op_kind_t k, logic [15:0] l, int rel);
    int c;
    @(negedge core_clk);
    opKind = k;
    regList = l;
    opStart = 1;
    wq.delete();
    nbw = 0;
    nfl = 0;
    nex = 0;
    @(negedge core_clk);
    opStart = 0;
    c = 0;
    while (busy === 1'b1 && c < 20)
    begin
      c++;
      if (c == rel)
        regWrReady = 1;
      ra[c] = address;
      wd[c] = writeData;
      rf[c] = {compressedIsaOut, writeNotRead, memoryRequestN, consecutiveAccess, instructionFetchN,
        privilegedAccessN, busLock, accessSize};
      @(negedge core_clk);
    end
    nrow = c;
    if (c == 20)
    begin
      chk("timeout", 0, 1);
      final_report();
    end
    repeat (3) @(negedge core_clk);
  endtask
  task automatic t_load2();
    run(mtbs_pkg::OP_LOAD, 16'h0006, 0);
    chk("c1 addr", PC + 8, ra[1]);
    chk("c1 row", 9'h00a, rf[1]);
    chk("c2 addr", FA, ra[2]);
    chk("c2 row", 4'h3, rf[2][7:4]);
    chk("c3 row", {FA + 4, 4'h5}, {ra[3], rf[3][7:4]});
    chk("c4 row", {PC + 12, 4'h3}, {ra[4], rf[4][7:4]});
    chk("rows", 4, nrow);
    chk("word1", {4'h1, FA ^ K}, wq[0]);
    chk("word2", {4'h2, (FA + 4) ^ K}, wq[1]);
    chk("base", {4'h1, 32'h2040}, {nbw[3:0], bwd});
    chk("base idx", 4'h5, baseWrIndex);
  endtask
  task automatic t_loadpc();
    run(mtbs_pkg::OP_LOAD, 16'h8008, 0);
    chk("n2 row", 4'h1, rf[4][7:4]);
    chk("n3 row", {(FA + 4) ^ K, 4'h2}, {ra[5], rf[5][7:4]});
    chk("n4 addr", ((FA + 4) ^ K) + 4, ra[6]);
    chk("flush", 1, nfl);
    chk("pc word", {4'hf, (FA + 4) ^ K}, wq[1]);
  endtask
  task automatic t_stall();
    regWrReady = 0;
    run(mtbs_pkg::OP_LOAD, 16'h000e, 9);
    chk("words", 3, wq.size());
    for (int i = 0; i < 3; i++)
      chk("order", {4'(i + 1), (FA + 32'(4 * i)) ^ K}, wq[i]);
  endtask
  task automatic t_abort();
    abortOn = 1;
    abortAt = FA + 4;
    run(mtbs_pkg::OP_LOAD, 16'h8006, 0);
    abortOn = 0;
    chk("kept n", 1, wq.size());
    chk("kept", {4'h1, FA ^ K}, wq[0]);
    chk("flush", 0, nfl);
    chk("restore", {4'h2, 32'h2040}, {nbw[3:0], bwd});
  endtask
  task automatic t_store();
    run(mtbs_pkg::OP_STORE, 16'h0012, 0);
    chk("s2 row", {FA, 4'hb}, {ra[2], rf[2][7:4]});
    chk("s2 data", SD ^ 1, wd[2]);
    chk("s3 row", {FA + 4, 4'h9}, {ra[3], rf[3][7:4]});
    chk("s3 data", SD ^ 4, wd[3]);
    chk("rows", 3, nrow);
  endtask
  task automatic t_swap();
    for (int i = 0; i < 2; i++)
    begin
      swapByte = !i;
      abortOn = (i == 1);
      abortAt = FA;
      run(mtbs_pkg::OP_SWAP, 16'h0, 0);
      chk("w2", {FA, 4'h1, 1'b1, i ? 2'h2 : 2'h0}, {ra[2], rf[2][7:4], rf[2][2:0]});
      chk("w3", {FA, 4'hd, 1'b1}, {ra[3], rf[3][7:4], rf[3][2]});
      chk("w3 data", 32'h0bad0bad, wd[3]);
      chk("w4", {PC + 12, 4'h3, 3'b010}, {ra[4], rf[4][7:4], rf[4][2:0]});
      chk("dest", i ? 0 : {4'h7, FA ^ K}, i ? wq.size() : wq[0]);
    end
    abortOn = 0;
    compressedIsaState = 1;
    run(mtbs_pkg::OP_SWAP, 16'h0, 0);
    chk("refused", 0, nrow);
    compressedIsaState = 0;
  endtask
  task automatic t_exc();
    logic [31:0] b, l;
    userMode = 1;
    for (int i = 0; i < 4; i++)
    begin
      compressedIsaState = (i == 1);
      excKind = mtbs_pkg::exc_kind_t'(i);
      l = (i == 1) ? 2 : 4;
      b = (i < 2) ? PC : PC + l;
      run(mtbs_pkg::OP_EXC, 16'h0, 0);
      chk("x1 addr", b + 2 * l, ra[1]);
      chk("x1 row", {i == 1, 6'h0, i == 1 ? 2'h1 : 2'h2}, rf[1]);
      chk("x2", {32'h1c, 9'h02a}, {ra[2], rf[2]});
      chk("x3", {32'h20, 9'h02a}, {ra[3], rf[3]});
      chk("link1", {4'he, b}, wq[0]);
      chk("link2", {4'he, b + l}, wq[1]);
      chk("mode", 1, nex);
    end
    compressedIsaState = 0;
    userMode = 0;
  endtask
  initial
  begin
    repeat (2) @(negedge core_clk);
    reset_n = 1;
    repeat (3) @(negedge core_clk);
    t_load2();
    t_loadpc();
    t_stall();
    t_abort();
    t_store();
    t_swap();
    t_exc();
    final_report();
  end
endmodule // multi_transfer_bus_sequencer_tb
`default_nettype wire
